// file: hw/cspr_pkg.sv
// Constants, types and carriers for the CPU system pointer registers.
// Assumes one 50 MHz clock and a sequencer on that clock that drives
// one operation or one data memory nibble access at a time.
// How it works
// RULE_01: Program address spans 74H-77H, ten bits live
// RULE_02: Reset clears all program address bits
// RULE_03: Table read copies program word into buffer
// RULE_04: Push decrements stack pointer, then writes entry
// RULE_05: Pop loads register first, then increments pointer
// RULE_06: Indirect jump loads counter from program address
// RULE_07: Indirect call targets program address location
// RULE_08: Dedicated increment adds one to program address
// RULE_09: Data memory accesses program address per nibble
// RULE_10: Put and get move sixteen bits
// RULE_11: Window register unreset, keeps contents across reset
// RULE_12: Window register carries peek and poke data
// RULE_13: Bank register at 79H reads zero
// RULE_14: Index spans 7AH-7CH, enable in status bit0
// RULE_15: Index enable ORs index into direct address
// RULE_16: Index upper bits fixed zero, bank zero
// RULE_17: Row pointer shares 7AH/7BH, 7AH msb enables
// RULE_18: Row pointer enable supplies indirect bank, row
// RULE_19: Row from low three bits, bank forced zero
// RULE_20: Both enables clear leave addresses unmodified
// RULE_21: Index, pointer and status flags reset zero
// RULE_22: Fixed-zero bits ignore writes, read zero
package cspr_pkg;
  // Data memory nibble addresses of the system registers
  localparam logic [6:0] ADDR_PA_NIB3 = 7'h74;
  localparam logic [6:0] ADDR_PA_NIB2 = 7'h75;
  localparam logic [6:0] ADDR_PA_NIB1 = 7'h76;
  localparam logic [6:0] ADDR_PA_NIB0 = 7'h77;
  localparam logic [6:0] ADDR_WINDOW = 7'h78;
  localparam logic [6:0] ADDR_BANK = 7'h79;
  localparam logic [6:0] ADDR_IDX_UPPER = 7'h7a;
  localparam logic [6:0] ADDR_IDX_MIDDLE = 7'h7b;
  localparam logic [6:0] ADDR_IDX_LOWER = 7'h7c;
  localparam logic [6:0] ADDR_GRP_UPPER = 7'h7d;
  localparam logic [6:0] ADDR_GRP_LOWER = 7'h7e;
  localparam logic [6:0] ADDR_STATUS = 7'h7f;
  localparam logic [6:0] ADDR_SYS_FIRST = 7'h74;
  // Field positions and widths
  localparam int PA_W = 10;
  localparam int WORD_W = 16;
  localparam int ENABLE_BIT_MPE = 3;
  localparam int ENABLE_BIT_IXE = 0;
  // Reset and fixed values
  localparam logic [PA_W-1:0] PA_RESET = 10'h000;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [2:0] ROW_ZERO = 3'h0;
  localparam logic [5:0] PA_PAD = 6'h00;
  localparam logic [PA_W-1:0] PA_ONE = 10'h001;

  // Operations issued by the instruction sequencer
  typedef enum logic [3:0] {
    OP_NONE,
    OP_INC,
    OP_PUSH,
    OP_POP,
    OP_TABLE_READ,
    OP_JUMP,
    OP_CALL,
    OP_PUT,
    OP_GET,
    OP_PEEK,
    OP_POKE
  } cspr_op_e;

  // One data memory nibble access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [3:0] wdata;
  } cspr_dm_req_s;

  // Operand of an address-modified instruction
  typedef struct packed {
    logic [2:0] row;
    logic [3:0] col;
    logic [2:0] gr_row;
    logic [3:0] gr_val;
  } cspr_operand_s;

  // Modified data memory address
  typedef struct packed {
    logic [3:0] bank;
    logic [2:0] row;
    logic [3:0] col;
  } cspr_dm_addr_s;
endpackage

// file: hw/cspr_sysreg.sv
// CPU system pointer registers: program address, window, bank, index,
// row pointer and the index enable flag of the status nibble.
// Assumes the sequencer on ref_clk issues an operation only while
// op_ready_r is high and that stack pointer, program memory, data
// buffer and register file are kept by logic on the same clock.
`timescale 1ns/10ps
module cspr_sysreg (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire cspr_pkg::cspr_op_e op_code,
  output logic op_ready_r,
  input wire cspr_pkg::cspr_dm_req_s dm_req,
  output logic [3:0] dm_rdata_r,
  output logic dm_hit_r,
  input wire cspr_pkg::cspr_operand_s operand,
  output cspr_pkg::cspr_dm_addr_s direct_addr_r,
  output cspr_pkg::cspr_dm_addr_s indirect_addr_r,
  output logic stack_dec_r,
  output logic stack_inc_r,
  output logic stack_wr_r,
  output logic [cspr_pkg::PA_W-1:0] stack_wdata_r,
  input wire logic [cspr_pkg::PA_W-1:0] stack_rdata,
  output logic pm_rd_r,
  output logic [cspr_pkg::PA_W-1:0] pm_addr_r,
  input wire logic pm_rvalid,
  input wire logic [cspr_pkg::WORD_W-1:0] pm_rdata,
  output logic pc_load_r,
  output logic pc_call_r,
  output logic [cspr_pkg::PA_W-1:0] pc_target_r,
  output logic dbf_wr_r,
  output logic [cspr_pkg::WORD_W-1:0] dbf_wdata_r,
  input wire logic [cspr_pkg::WORD_W-1:0] dbf_rdata,
  output logic rf_wr_r,
  output logic [3:0] rf_wdata_r,
  input wire logic [3:0] rf_rdata
);
  import cspr_pkg::*;

  // Sequencing states for the multi-cycle operations
  // Single-cycle operations never leave idle
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PUSH_WR,
    ST_POP_INC,
    ST_TBL_WAIT
  } cspr_state_e;

  cspr_state_e state_r; // Current sequence step
  cspr_state_e state_nxt; // Next sequence step
  logic [PA_W-1:0] pa_r; // Ten live bits of the program address
  logic [3:0] window_r; // Window register, never reset
  logic row_ptr_en_r; // Row pointer enable flag
  logic [2:0] idx_mid_r; // Middle index bits, also row pointer row
  logic [3:0] idx_low_r; // Lower index nibble
  logic idx_en_r; // Index enable flag
  logic accept; // Operation taken this cycle
  logic dm_wr_hit; // Nibble write aimed at a system register
  logic [3:0] rd_mux; // Read value of the addressed nibble

  assign accept = op_valid && (state_r == ST_IDLE);
  assign dm_wr_hit = dm_req.wr && (dm_req.addr >= ADDR_SYS_FIRST);

  // Next step of the operation sequencer
  // Operations seen while busy are ignored, not queued
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (op_valid) begin
          case (op_code)
            OP_PUSH: state_nxt = ST_PUSH_WR;
            OP_POP: state_nxt = ST_POP_INC;
            OP_TABLE_READ: state_nxt = ST_TBL_WAIT;
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      // One extra cycle each, then back to idle
      ST_PUSH_WR: state_nxt = ST_IDLE;
      ST_POP_INC: state_nxt = ST_IDLE;
      // Wait for the program memory word
      ST_TBL_WAIT: begin
        if (pm_rvalid) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register and ready flag
  // Ready returns with the table read's buffer write pulse,
  // so a get must let that write land before it is issued
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_ready_r <= (state_nxt == ST_IDLE);
    end
  end

  // Program address register: operations win over nibble writes
  // A same-cycle nibble write to the address is dropped
  // Increment wraps from the top of the ten-bit range
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pa_r <= PA_RESET; // RULE_02
    end else if (accept && op_code == OP_INC) begin
      pa_r <= pa_r + PA_ONE; // RULE_08
    end else if (accept && op_code == OP_POP) begin
      pa_r <= stack_rdata; // RULE_05
    end else if (accept && op_code == OP_GET) begin
      pa_r <= dbf_rdata[PA_W-1:0]; // RULE_10
    end else if (dm_wr_hit) begin
      // Per-nibble writes; the six upper bits are not stored
      case (dm_req.addr)
        ADDR_PA_NIB2: pa_r[9:8] <= dm_req.wdata[1:0]; // RULE_09 RULE_22
        ADDR_PA_NIB1: pa_r[7:4] <= dm_req.wdata; // RULE_09
        ADDR_PA_NIB0: pa_r[3:0] <= dm_req.wdata; // RULE_09
        default: pa_r <= pa_r;
      endcase
    end
  end

  // Window register: no reset so halt or stop release keeps it
  // Undefined until the first peek or nibble write
  always_ff @(posedge ref_clk) begin
    if (accept && op_code == OP_PEEK) begin
      window_r <= rf_rdata; // RULE_11 RULE_12
    end else if (dm_wr_hit && dm_req.addr == ADDR_WINDOW) begin
      window_r <= dm_req.wdata; // RULE_11
    end
  end

  // Index, row pointer and status flag nibbles
  // Both enables may be set; each then acts on its own
  // Only live bits are stored, fixed-zero bits cost no flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      row_ptr_en_r <= 1'b0; // RULE_21
      idx_mid_r <= ROW_ZERO; // RULE_21
      idx_low_r <= NIB_ZERO; // RULE_21
      idx_en_r <= 1'b0; // RULE_21
    end else if (dm_wr_hit) begin
      case (dm_req.addr)
        // Only the enable flag is stored; upper index bits stay zero
        ADDR_IDX_UPPER: row_ptr_en_r <= dm_req.wdata[ENABLE_BIT_MPE]; // RULE_17 RULE_16
        // Top bit selects a bank, so it is fixed at zero
        ADDR_IDX_MIDDLE: idx_mid_r <= dm_req.wdata[2:0]; // RULE_14 RULE_19
        ADDR_IDX_LOWER: idx_low_r <= dm_req.wdata; // RULE_14
        // Other status flags live elsewhere in the core
        ADDR_STATUS: idx_en_r <= dm_req.wdata[ENABLE_BIT_IXE]; // RULE_14
        default: idx_en_r <= idx_en_r;
      endcase
    end
  end

  // Read value of each system register nibble
  always_comb begin
    case (dm_req.addr)
      ADDR_PA_NIB3: rd_mux = NIB_ZERO; // RULE_01
      ADDR_PA_NIB2: rd_mux = {2'h0, pa_r[9:8]}; // RULE_01 RULE_22
      ADDR_PA_NIB1: rd_mux = pa_r[7:4]; // RULE_09
      ADDR_PA_NIB0: rd_mux = pa_r[3:0]; // RULE_09
      ADDR_WINDOW: rd_mux = window_r;
      ADDR_BANK: rd_mux = NIB_ZERO; // RULE_13
      ADDR_IDX_UPPER: rd_mux = {row_ptr_en_r, ROW_ZERO}; // RULE_16 RULE_17
      ADDR_IDX_MIDDLE: rd_mux = {1'b0, idx_mid_r}; // RULE_19
      ADDR_IDX_LOWER: rd_mux = idx_low_r;
      ADDR_STATUS: rd_mux = {ROW_ZERO, idx_en_r};
      // General register pointer is kept outside this block
      default: rd_mux = NIB_ZERO;
    endcase
  end

  // Registered read answer, one cycle after the request
  // Read data holds between reads so a slow reader can look
  // Hit flags only reads inside the system register range
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dm_rdata_r <= NIB_ZERO;
      dm_hit_r <= 1'b0;
    end else begin
      dm_hit_r <= dm_req.rd && (dm_req.addr >= ADDR_SYS_FIRST);
      if (dm_req.rd) begin
        dm_rdata_r <= rd_mux;
      end
    end
  end

  // Address modification, registered one cycle after the operand
  // Enables and operand of the previous cycle shape each address
  // Bank bits of index and row pointer are never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      direct_addr_r <= '0;
      indirect_addr_r <= '0;
    end else begin
      // Bank is bank register OR upper index, both zero
      direct_addr_r.bank <= NIB_ZERO; // RULE_16
      if (idx_en_r) begin
        direct_addr_r.row <= operand.row | idx_mid_r; // RULE_15
        direct_addr_r.col <= operand.col | idx_low_r; // RULE_15
      end else begin
        direct_addr_r.row <= operand.row; // RULE_20
        direct_addr_r.col <= operand.col; // RULE_20
      end
      // Bank from row pointer upper bits, fixed zero either way
      indirect_addr_r.bank <= NIB_ZERO; // RULE_19
      indirect_addr_r.col <= operand.gr_val; // RULE_18
      if (row_ptr_en_r) begin
        indirect_addr_r.row <= idx_mid_r; // RULE_18 RULE_19
      end else begin
        indirect_addr_r.row <= operand.gr_row; // RULE_20
      end
    end
  end

  // Stack handshakes for push and pop
  // Pointer lives outside; this side only pulses in order
  // Written value is the register as it stands in the decrement cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stack_dec_r <= 1'b0;
      stack_inc_r <= 1'b0;
      stack_wr_r <= 1'b0;
      stack_wdata_r <= PA_RESET;
    end else begin
      // Decrement first, entry written the cycle after
      stack_dec_r <= accept && op_code == OP_PUSH; // RULE_04
      stack_wr_r <= state_r == ST_PUSH_WR; // RULE_04
      // Increment follows the load of the register
      stack_inc_r <= state_r == ST_IDLE && state_nxt == ST_POP_INC; // RULE_05
      if (state_r == ST_PUSH_WR) begin
        stack_wdata_r <= pa_r; // RULE_04
      end
    end
  end

  // Program memory read for table reference
  // Address is latched so later nibble writes cannot disturb it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pm_rd_r <= 1'b0;
      pm_addr_r <= PA_RESET;
    end else begin
      pm_rd_r <= accept && op_code == OP_TABLE_READ; // RULE_03
      if (accept && op_code == OP_TABLE_READ) begin
        pm_addr_r <= pa_r; // RULE_03
      end
    end
  end

  // Program counter loads for indirect jump and call
  // Jump and call share one latched target
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_load_r <= 1'b0;
      pc_call_r <= 1'b0;
      pc_target_r <= PA_RESET;
    end else begin
      pc_load_r <= accept && op_code == OP_JUMP; // RULE_06
      pc_call_r <= accept && op_code == OP_CALL; // RULE_07
      if (accept && (op_code == OP_JUMP || op_code == OP_CALL)) begin
        pc_target_r <= pa_r; // RULE_06 RULE_07
      end
    end
  end

  // Data buffer writes from put and table read
  // Put pads the six upper bits with zero
  // Table read writes the fetched word one cycle after it is valid
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dbf_wr_r <= 1'b0;
      dbf_wdata_r <= '0;
    end else begin
      dbf_wr_r <= 1'b0;
      if (accept && op_code == OP_PUT) begin
        dbf_wr_r <= 1'b1; // RULE_10
        dbf_wdata_r <= {PA_PAD, pa_r}; // RULE_10 RULE_01
      end else if (state_r == ST_TBL_WAIT && pm_rvalid) begin
        dbf_wr_r <= 1'b1; // RULE_03
        dbf_wdata_r <= pm_rdata; // RULE_03
      end
    end
  end

  // Register file write for poke
  // Poke sends the window value as it stood at acceptance
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rf_wr_r <= 1'b0;
      rf_wdata_r <= NIB_ZERO;
    end else begin
      rf_wr_r <= accept && op_code == OP_POKE; // RULE_12
      if (accept && op_code == OP_POKE) begin
        rf_wdata_r <= window_r; // RULE_12
      end
    end
  end

  // Reset leaves program address and enables clear
  // Window is left out on purpose, it keeps its value
  reset_clear_a: assert property ( // RULE_02 RULE_21
    @(posedge ref_clk)
    !rst_n |=> (pa_r == PA_RESET && !idx_en_r && !row_ptr_en_r))
    else $error("reset did not clear address state");

  // Push: decrement, then write the old register value
  // Data is taken in the decrement cycle, written the cycle after
  push_order_a: assert property ( // RULE_04
    @(posedge ref_clk) disable iff (!rst_n)
    stack_dec_r |=> (stack_wr_r && stack_wdata_r == $past(pa_r)))
    else $error("push order or data wrong");

  // Pop: register loaded before increment
  // Entry is read while the pointer still selects it
  pop_order_a: assert property ( // RULE_05
    @(posedge ref_clk) disable iff (!rst_n)
    stack_inc_r |-> (pa_r == $past(stack_rdata) && !stack_dec_r))
    else $error("pop order or data wrong");

  // Jump target equals the address register
  // Target is the value at acceptance, not a later one
  jump_target_a: assert property ( // RULE_06
    @(posedge ref_clk) disable iff (!rst_n)
    (accept && op_code == OP_JUMP) |=> (pc_load_r && pc_target_r == $past(pa_r)))
    else $error("indirect jump target wrong");

  // Increment adds exactly one
  // Wrap from all ones to zero is part of the check
  inc_step_a: assert property ( // RULE_08
    @(posedge ref_clk) disable iff (!rst_n)
    (accept && op_code == OP_INC) |=> (pa_r == $past(pa_r) + PA_ONE))
    else $error("increment wrong");

  // Bank and upper nibble always read zero
  // Writes of ones to these nibbles must not show up
  fixed_zero_a: assert property ( // RULE_13
    @(posedge ref_clk) disable iff (!rst_n)
    (dm_req.rd && (dm_req.addr == ADDR_BANK || dm_req.addr == ADDR_PA_NIB3)) |=> dm_rdata_r == NIB_ZERO)
    else $error("fixed zero nibble read nonzero");

  // Index modification ORs the index into the operand
  // Column is checked; row takes the same path
  index_or_a: assert property ( // RULE_15
    @(posedge ref_clk) disable iff (!rst_n)
    idx_en_r |=> direct_addr_r.col == ($past(operand.col) | $past(idx_low_r)))
    else $error("index modification wrong");

  // Row pointer supplies the indirect row
  // Bank stays zero whatever the pointer holds
  row_ptr_a: assert property ( // RULE_18
    @(posedge ref_clk) disable iff (!rst_n)
    row_ptr_en_r |=> (indirect_addr_r.row == $past(idx_mid_r) && indirect_addr_r.bank == NIB_ZERO))
    else $error("row pointer modification wrong");

  // Poke sends the window value to the register file
  // Window as it stood when the poke was accepted
  poke_data_a: assert property ( // RULE_12
    @(posedge ref_clk) disable iff (!rst_n)
    (accept && op_code == OP_POKE) |=> (rf_wr_r && rf_wdata_r == $past(window_r)))
    else $error("poke data wrong");

  // Table read ends in a buffer write of the fetched word
  // Word is the one standing in its valid cycle
  table_done_a: assert property ( // RULE_03
    @(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_TBL_WAIT && pm_rvalid) |=> (dbf_wr_r && dbf_wdata_r == $past(pm_rdata)))
    else $error("table read data wrong");
endmodule

// file: verif/cspr_periph_model.sv
// Model of the stack, program memory, data buffer and register file.
// Assumes single-cycle request pulses from the register block on ref_clk.
`timescale 1ns/10ps
module cspr_periph_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic stack_dec_r,
  input wire logic stack_inc_r,
  input wire logic stack_wr_r,
  input wire logic [9:0] stack_wdata_r,
  output logic [9:0] stack_rdata,
  input wire logic pm_rd_r,
  input wire logic [9:0] pm_addr_r,
  output logic pm_rvalid,
  output logic [15:0] pm_rdata,
  input wire logic dbf_wr_r,
  input wire logic [15:0] dbf_wdata_r,
  output logic [15:0] dbf_rdata,
  input wire logic rf_wr_r,
  input wire logic [3:0] rf_wdata_r,
  output logic [3:0] rf_rdata
);
  logic [9:0] stk_r [8]; // Address stack entries
  logic [2:0] sp_r; // Stack pointer
  logic [2:0] wait_r; // Fetch wait count
  logic busy_r; // Fetch in flight
  logic [15:0] word_r; // Fetched word
  // Entry selected now
  assign stack_rdata = stk_r[sp_r];
  // Word is inverted outside its valid cycle, so a late sample is caught
  assign pm_rdata = pm_rvalid ? word_r : ~word_r;
  // Stack pointer moves before or after the entry access as pulsed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sp_r <= 3'h0;
    end else begin
      sp_r <= sp_r - {2'h0, stack_dec_r} + {2'h0, stack_inc_r};
      if (stack_wr_r) begin
        stk_r[sp_r] <= stack_wdata_r;
      end
    end
  end
  // Program memory, prompt or four cycles slow
  always_ff @(posedge ref_clk) begin
    pm_rvalid <= 1'b0;
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (pm_rd_r) begin
      busy_r <= 1'b1;
      wait_r <= slow ? 3'h4 : 3'h0;
      word_r <= {pm_addr_r[5:0], pm_addr_r} ^ 16'ha5c3;
    end else if (busy_r && wait_r == 3'h0) begin
      busy_r <= 1'b0;
      pm_rvalid <= 1'b1;
    end else if (busy_r) begin
      wait_r <= wait_r - 3'h1;
    end
  end
  // Data buffer and register file nibble
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dbf_rdata <= 16'h0000;
      rf_rdata <= 4'hc;
    end else begin
      if (dbf_wr_r) dbf_rdata <= dbf_wdata_r;
      if (rf_wr_r) rf_rdata <= rf_wdata_r;
    end
  end
endmodule

// file: verif/cspr_testbench.sv
// Self-checking bench for the system pointer registers.
// Assumes the periph model on the far side and a 50 MHz ref_clk.
`timescale 1ns/10ps
module testbench;
  import cspr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic slow = 1'b0;
  cspr_op_e op_code = OP_NONE;
  cspr_dm_req_s dm_req = '0;
  cspr_operand_s operand = '0;
  logic op_ready_r, dm_hit_r, stack_dec_r, stack_inc_r, stack_wr_r, pm_rd_r, pm_rvalid;
  logic pc_load_r, pc_call_r, dbf_wr_r, rf_wr_r;
  logic [3:0] dm_rdata_r, rf_wdata_r, rf_rdata;
  logic [9:0] stack_wdata_r, stack_rdata, pm_addr_r, pc_target_r, v;
  logic [15:0] pm_rdata, dbf_wdata_r, dbf_rdata, w;
  cspr_dm_addr_s direct_addr_r, indirect_addr_r, ed, ei;
  logic [3:0] rd_q [$]; // Expected read nibbles
  logic [11:0] pc_q [$]; // Expected {call, load, target}
  logic [3:0] mask_t [12] = '{4'h0, 4'h3, 4'hf, 4'hf, 4'hf, 4'h0, 4'h8, 4'h7, 4'hf, 4'h0, 4'h0, 4'h1};
  logic [3:0] d;
  logic [7:0] ix;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed;
  cspr_sysreg cspr_sysreg_i (.ref_clk, .rst_n, .op_valid, .op_code, .op_ready_r, .dm_req, .dm_rdata_r,
    .dm_hit_r, .operand, .direct_addr_r, .indirect_addr_r, .stack_dec_r, .stack_inc_r, .stack_wr_r,
    .stack_wdata_r, .stack_rdata, .pm_rd_r, .pm_addr_r, .pm_rvalid, .pm_rdata, .pc_load_r, .pc_call_r,
    .pc_target_r, .dbf_wr_r, .dbf_wdata_r, .dbf_rdata, .rf_wr_r, .rf_wdata_r, .rf_rdata);
  cspr_periph_model cspr_periph_model_i (.ref_clk, .rst_n, .slow, .stack_dec_r, .stack_inc_r, .stack_wr_r,
    .stack_wdata_r, .stack_rdata, .pm_rd_r, .pm_addr_r, .pm_rvalid, .pm_rdata, .dbf_wr_r, .dbf_wdata_r,
    .dbf_rdata, .rf_wr_r, .rf_wdata_r, .rf_rdata);
  // Free-running clock
  always #10 ref_clk = ~ref_clk;
  // Closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Nibble access held until the next call replaces it
  task automatic dm_go(input logic rd, input logic [6:0] a, input logic [3:0] dd);
    @(posedge ref_clk);
    dm_req <= {rd, !rd, a, dd};
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] dd);
    dm_go(1'b0, a, dd);
  endtask
  task automatic rd(input logic [6:0] a, input logic [3:0] e);
    rd_q.push_back(e);
    dm_go(1'b1, a, 4'h0);
  endtask
  task automatic set_pa(input logic [9:0] p);
    wr(ADDR_PA_NIB2, {2'h0, p[9:8]});
    wr(ADDR_PA_NIB1, p[7:4]);
    wr(ADDR_PA_NIB0, p[3:0]);
  endtask
  task automatic chk_pa(input logic [9:0] p);
    rd(ADDR_PA_NIB2, {2'h0, p[9:8]});
    rd(ADDR_PA_NIB1, p[7:4]);
    rd(ADDR_PA_NIB0, p[3:0]);
  endtask
  // Request held until an edge samples op_ready_r high
  task automatic op_go(input cspr_op_e c);
    @(posedge ref_clk);
    dm_req <= '0;
    op_valid <= 1'b1;
    op_code <= c;
    do @(posedge ref_clk); while (op_ready_r !== 1'b1);
    op_valid <= 1'b0;
  endtask
  // Result watcher takes the oldest note per result
  always @(posedge ref_clk) begin
    if (dm_hit_r === 1'b1) begin
      chk({12'h000, dm_rdata_r}, (rd_q.size() > 0) ? {12'h000, rd_q.pop_front()} : 16'hdead);
    end
    if (pc_load_r === 1'b1 || pc_call_r === 1'b1) begin
      chk({4'h0, pc_call_r, pc_load_r, pc_target_r},
        (pc_q.size() > 0) ? {4'h0, pc_q.pop_front()} : 16'hdead);
    end
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    seed = 70737;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 12; i++) if (i != 4) rd(7'(ADDR_SYS_FIRST + i), 4'h0);
    $display("done reset values");
    for (int j = 0; j < 3; j++) begin
      for (int i = 0; i < 12; i++) begin
        d = (j == 0) ? 4'hf : 4'($random(seed));
        wr(7'(ADDR_SYS_FIRST + i), d);
        rd(7'(ADDR_SYS_FIRST + i), d & mask_t[i]);
      end
    end
    $display("done nibble access");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 10'h3ff : (k == 1) ? 10'h0ff : 10'($random(seed));
      set_pa(v);
      op_go(OP_INC);
      chk_pa(10'(v + 10'h001));
    end
    for (int k = 0; k < 4; k++) begin
      v = 10'($random(seed));
      set_pa(v);
      pc_q.push_back({k[0], !k[0], v});
      op_go(k[0] ? OP_CALL : OP_JUMP);
    end
    $display("done increment and branch");
    set_pa(10'h2a5);
    op_go(OP_PUSH);
    set_pa(10'h15a);
    op_go(OP_PUSH);
    set_pa(10'h000);
    op_go(OP_POP);
    chk_pa(10'h15a);
    op_go(OP_POP);
    chk_pa(10'h2a5);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      v = 10'($random(seed));
      set_pa(v);
      op_go(OP_TABLE_READ);
      // Ready comes back with the buffer write; let it land before the get
      do @(posedge ref_clk); while (dbf_wr_r !== 1'b1);
      op_go(OP_GET);
      w = {v[5:0], v} ^ 16'ha5c3;
      chk_pa(w[9:0]);
    end
    set_pa(10'h1c7);
    op_go(OP_PUT);
    set_pa(10'h000);
    op_go(OP_GET);
    chk_pa(10'h1c7);
    $display("done stack and transfers");
    op_go(OP_PEEK);
    rd(ADDR_WINDOW, 4'hc);
    wr(ADDR_WINDOW, 4'h5);
    op_go(OP_POKE);
    wr(ADDR_WINDOW, 4'h0);
    op_go(OP_PEEK);
    rd(ADDR_WINDOW, 4'h5);
    $display("done window");
    for (int k = 0; k < 16; k++) begin
      ix = 8'($random(seed));
      wr(ADDR_IDX_MIDDLE, ix[7:4]);
      wr(ADDR_IDX_LOWER, ix[3:0]);
      wr(ADDR_IDX_UPPER, {k[1], 3'h0});
      wr(ADDR_STATUS, {3'h0, k[0]});
      @(posedge ref_clk);
      dm_req <= '0;
      operand <= 14'($random(seed));
      repeat (2) @(posedge ref_clk);
      ed = {4'h0, k[0] ? operand.row | ix[6:4] : operand.row, k[0] ? operand.col | ix[3:0] : operand.col};
      ei = {4'h0, k[1] ? ix[6:4] : operand.gr_row, operand.gr_val};
      chk(16'(direct_addr_r), 16'(ed));
      chk(16'(indirect_addr_r), 16'(ei));
    end
    $display("done address modification");
    wr(ADDR_WINDOW, 4'ha);
    set_pa(10'h3c3);
    @(posedge ref_clk);
    dm_req <= '0;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_WINDOW, 4'ha);
    rd(ADDR_PA_NIB0, 4'h0);
    rd(ADDR_STATUS, 4'h0);
    @(posedge ref_clk);
    dm_req <= '0;
    repeat (4) @(posedge ref_clk);
    $display("done second reset");
    chk(16'(rd_q.size() + pc_q.size()), 16'h0000);
    print_verdict();
  end
endmodule
